// ### hdl/trc_timer.sv
// eight-bit free-running / reload timer with nibble-wide cpu registers
module trc_timer #(
  parameter int PRESC_W = trc_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_nrst,
  // cpu timing and power state
  input  wire logic                        i_cyc_tick,
  input  wire logic                        i_stop,
  // nibble register access
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [trc_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic [3:0]                  i_reg_wdata,
  output logic      [3:0]                  o_reg_rdata,
  // single-bit manipulation of the flag area
  input  wire logic                        i_bit_wr,
  input  wire logic [trc_pkg::ADDR_W-1:0]  i_bit_addr,
  input  wire logic [1:0]                  i_bit_pos,
  input  wire logic                        i_bit_val,
  // events and pin
  output logic                             o_ovf_irq,
  output logic                             o_wdog_reset,
  output logic                             o_waveform_output_pin
);

  // elaboration stops on a prescaler too short for the slowest clock
  if (PRESC_W < trc_pkg::PRESC_W)
  begin
    $error("prescaler too narrow for the slowest clock");
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and watchdog flag

  logic [PRESC_W:1] div_tick;
  logic             wdog_set;
  logic             watchdog_enable_flag;

  trc_prescaler #(
    .PRESC_W    (PRESC_W)
  ) u_system_prescaler (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_cyc_tick (i_cyc_tick),
    .o_div_tick (div_tick)
  );

  assign wdog_set = i_bit_wr
                  & (i_bit_addr == trc_pkg::ADDR_FLAG_AREA)
                  & (i_bit_pos == trc_pkg::WDOG_FLAG_POS);

  trc_wdog_flag u_wdog_flag (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_bit_wr   (wdog_set),
    .i_bit_val  (i_bit_val),
    .o_flag     (watchdog_enable_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_mode;
  logic wr_port;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;

  assign wr_mode = i_reg_wr & (i_reg_addr == trc_pkg::ADDR_MODE);
  assign wr_port = i_reg_wr & (i_reg_addr == trc_pkg::ADDR_PORT_MODE);
  assign wr_low  = i_reg_wr & (i_reg_addr == trc_pkg::ADDR_CNT_LOW);
  assign wr_high = i_reg_wr & (i_reg_addr == trc_pkg::ADDR_CNT_HIGH);
  assign rd_low  = i_reg_rd & (i_reg_addr == trc_pkg::ADDR_CNT_LOW);
  assign rd_high = i_reg_rd & (i_reg_addr == trc_pkg::ADDR_CNT_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // mode and write registers

  logic [3:0] timer_c_mode_r;
  logic [3:0] timer_c_mode_nxt;
  logic [3:0] port_mode_a_r;
  logic [3:0] port_mode_a_nxt;
  logic [3:0] reload_write_low_r;
  logic [3:0] reload_write_low_nxt;
  logic [3:0] reload_write_high_r;
  logic [3:0] reload_write_high_nxt;

  always_comb
  begin
    timer_c_mode_nxt      = timer_c_mode_r;
    port_mode_a_nxt       = port_mode_a_r;
    reload_write_low_nxt  = reload_write_low_r;
    reload_write_high_nxt = reload_write_high_r;
    if (i_stop)
      timer_c_mode_nxt = trc_pkg::MODE_RST;
    else if (wr_mode)
      timer_c_mode_nxt = i_reg_wdata;
    if (wr_port)
      port_mode_a_nxt = i_reg_wdata;
    if (wr_low)
      reload_write_low_nxt = i_reg_wdata;
    if (wr_high)
      reload_write_high_nxt = i_reg_wdata;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timer_c_mode_r      <= trc_pkg::MODE_RST;
      port_mode_a_r       <= trc_pkg::PORT_MODE_RST;
      reload_write_low_r  <= trc_pkg::NIBBLE_RST;
      reload_write_high_r <= trc_pkg::NIBBLE_RST;
    end
    else
    begin
      timer_c_mode_r      <= timer_c_mode_nxt;
      port_mode_a_r       <= port_mode_a_nxt;
      reload_write_low_r  <= reload_write_low_nxt;
      reload_write_high_r <= reload_write_high_nxt;
    end
  end

  logic       function_select_bit;
  logic [2:0] clock_sel;
  logic       cnt_tick;
  logic       at_top;

  assign function_select_bit = timer_c_mode_r[trc_pkg::FUNC_SEL_POS];
  assign clock_sel           = timer_c_mode_r[2:0];
  assign cnt_tick            = div_tick[trc_pkg::tap_of(clock_sel)];

  ////////////////////////////////////////////////////////////////////////////
  // timer counter, events and waveform

  logic [7:0] timer_c_counter_r;
  logic [7:0] timer_c_counter_nxt;
  logic       ovf_nxt;
  logic       wdog_reset_nxt;
  logic       wave_r;
  logic       wave_nxt;
  logic       pin_nxt;

  assign at_top = cnt_tick & (timer_c_counter_r == trc_pkg::COUNT_MAX);

  always_comb
  begin
    timer_c_counter_nxt = timer_c_counter_r;
    ovf_nxt             = at_top;
    wdog_reset_nxt      = at_top & watchdog_enable_flag;
    wave_nxt            = wave_r;
    // a high-nibble write loads at once and beats a same-cycle count
    if (wr_high)
      timer_c_counter_nxt = {i_reg_wdata, reload_write_low_r};
    else if (at_top)
    begin
      if (function_select_bit)
        timer_c_counter_nxt = {reload_write_high_r,
                               reload_write_low_r};
      else
        timer_c_counter_nxt = trc_pkg::COUNT_RST;
    end
    else if (cnt_tick)
      timer_c_counter_nxt = timer_c_counter_r + 8'h01;
    // duty is fixed at half by the toggle, period by two overflows spaced by 256 minus the reload value in ticks, or by 256 ticks when free-running
    if (at_top)
      wave_nxt = ~wave_r;
    pin_nxt = wave_nxt & port_mode_a_r[trc_pkg::WAVE_EN_POS];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timer_c_counter_r     <= trc_pkg::COUNT_RST;
      o_ovf_irq             <= 1'b0;
      o_wdog_reset          <= 1'b0;
      wave_r                <= 1'b0;
      o_waveform_output_pin <= 1'b0;
    end
    else
    begin
      timer_c_counter_r     <= timer_c_counter_nxt;
      o_ovf_irq             <= ovf_nxt;
      o_wdog_reset          <= wdog_reset_nxt;
      wave_r                <= wave_nxt;
      o_waveform_output_pin <= pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: upper nibble read latches the lower nibble for a clean pair

  logic [3:0] low_latch_r;
  logic [3:0] low_latch_nxt;
  logic [3:0] rdata_nxt;

  always_comb
  begin
    low_latch_nxt = low_latch_r;
    rdata_nxt     = 4'h0;
    if (rd_high)
    begin
      low_latch_nxt = timer_c_counter_r[3:0];
      rdata_nxt     = timer_c_counter_r[7:4];
    end
    else if (rd_low)
      rdata_nxt = low_latch_r;
    else if (i_reg_rd && (i_reg_addr == trc_pkg::ADDR_FLAG_AREA))
      rdata_nxt[trc_pkg::WDOG_FLAG_POS] = watchdog_enable_flag;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      low_latch_r <= trc_pkg::NIBBLE_RST;
      o_reg_rdata <= 4'h0;
    end
    else
    begin
      low_latch_r <= low_latch_nxt;
      o_reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_top_count;
    at_top && !wr_high;
  endsequence

  a_ovf_irq: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    at_top |=> o_ovf_irq)
    else $error("overflow without interrupt");

  a_ovf_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !at_top |=> !o_ovf_irq)
    else $error("interrupt without overflow");

  a_reload_value: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_top_count ##0 function_select_bit |=>
      timer_c_counter_r == {$past(reload_write_high_r),
                            $past(reload_write_low_r)})
    else $error("reload value not loaded on overflow");

  a_free_wrap: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_top_count ##0 !function_select_bit |=> timer_c_counter_r == 8'h00)
    else $error("free-running counter did not wrap to zero");

  a_count_step: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    cnt_tick && !at_top && !wr_high |=>
      timer_c_counter_r == $past(timer_c_counter_r) + 8'h01)
    else $error("counter did not advance by one");

  a_write_load: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    wr_high |=> timer_c_counter_r ==
      {$past(i_reg_wdata), $past(reload_write_low_r)})
    else $error("high write did not load the counter");

  a_stop_clear: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_stop |=> timer_c_mode_r == 4'h0)
    else $error("stop mode left the mode register set");

  a_mode_hidden: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_reg_rd && (i_reg_addr == trc_pkg::ADDR_MODE) |=> o_reg_rdata == 4'h0)
    else $error("mode register became readable");

  a_read_pair: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    rd_high ##1 rd_low |=> o_reg_rdata == $past(timer_c_counter_r[3:0], 2))
    else $error("low read did not return the latched nibble");

  a_read_high: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    rd_high |=> o_reg_rdata == $past(timer_c_counter_r[7:4]))
    else $error("high read returned the wrong nibble");

  a_wdog_fire: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    at_top && watchdog_enable_flag |=> o_wdog_reset)
    else $error("armed watchdog did not fire on overflow");

  a_wave_toggle: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    at_top |=> wave_r != $past(wave_r))
    else $error("waveform did not toggle on overflow");

endmodule

// ### hdl/trc_pkg.sv
// shared constants and helpers of the eight-bit reload timer
package trc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // nibble addresses of the cpu register space
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  ADDR_PORT_MODE  = 6'h04;
  localparam logic [5:0]  ADDR_MODE       = 6'h0D;
  localparam logic [5:0]  ADDR_CNT_LOW    = 6'h0E;
  localparam logic [5:0]  ADDR_CNT_HIGH   = 6'h0F;
  localparam logic [5:0]  ADDR_FLAG_AREA  = 6'h20;
  localparam logic [1:0]  WDOG_FLAG_POS   = 2'h1;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          FUNC_SEL_POS    = 3;
  localparam int          WAVE_EN_POS     = 0;

  //////////////////////////////////////////////////////////////////////////
  // values after reset and the top count
  localparam logic [3:0]  MODE_RST        = 4'h0;
  localparam logic [3:0]  PORT_MODE_RST   = 4'h0;
  localparam logic [3:0]  NIBBLE_RST      = 4'h0;
  localparam logic [7:0]  COUNT_RST       = 8'h00;
  localparam logic [7:0]  COUNT_MAX       = 8'hFF;

  //////////////////////////////////////////////////////////////////////////
  // prescaler: widest tap divides by 2048 instruction cycles
  localparam int          PRESC_W         = 11;

  // clock select code to prescaler tap (log2 of the divisor)
  function automatic logic [3:0] tap_of(input logic [2:0] sel);
    logic [3:0] t;
    t = 4'hB;
    unique case (sel)
      3'h0: t = 4'hB;
      3'h1: t = 4'hA;
      3'h2: t = 4'h9;
      3'h3: t = 4'h7;
      3'h4: t = 4'h5;
      3'h5: t = 4'h3;
      3'h6: t = 4'h2;
      3'h7: t = 4'h1;
    endcase
    return t;
  endfunction

endpackage

// ### hdl/trc_prescaler.sv
// instruction-cycle prescaler with one registered tick per power-of-two tap
module trc_prescaler #(
  parameter int PRESC_W = trc_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  // instruction cycle strobe
  input  wire logic               i_cyc_tick,
  // tick k pulses once every 2**k instruction cycles
  output logic      [PRESC_W:1]   o_div_tick
);

  // elaboration stops on a prescaler too short for the slowest clock
  if (PRESC_W < trc_pkg::PRESC_W)
  begin
    $error("prescaler too narrow for the slowest clock");
  end

  logic [PRESC_W-1:0] cnt_r;
  logic [PRESC_W-1:0] cnt_nxt;
  logic [PRESC_W:1]   tick_nxt;
  logic               run_ones;

  // running and of the low bits keeps every part-select constant
  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = '0;
    run_ones = i_cyc_tick;
    if (i_cyc_tick)
      cnt_nxt = cnt_r + 1'b1;
    for (int k = 1; k <= PRESC_W; k++)
    begin
      run_ones    = run_ones & cnt_r[k-1];
      tick_nxt[k] = run_ones;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_r      <= '0;
      o_div_tick <= '0;
    end
    else
    begin
      cnt_r      <= cnt_nxt;
      o_div_tick <= tick_nxt;
    end
  end

endmodule

// ### hdl/trc_wdog_flag.sv
// sticky watchdog enable flag: set by software, cleared only by reset
module trc_wdog_flag (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // single-bit write
  input  wire logic i_bit_wr,
  input  wire logic i_bit_val,
  // flag state
  output logic      o_flag
);

  logic flag_nxt;

  // a written zero is ignored on purpose: software cannot disarm it
  always_comb
  begin
    flag_nxt = o_flag | (i_bit_wr & i_bit_val);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_flag <= 1'b0;
    else
      o_flag <= flag_nxt;
  end

  a_flag_sticky: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_flag |=> o_flag)
    else $error("watchdog flag was cleared");

endmodule

// ### test/trc_timer_bench.sv
// self-checking bench for the eight-bit reload timer
module trc_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  logic       i_sys_clk;
  logic       i_nrst;
  logic       i_cyc_tick;
  logic       i_stop;
  logic       i_reg_wr;
  logic       i_reg_rd;
  logic [5:0] i_reg_addr;
  logic [3:0] i_reg_wdata;
  logic [3:0] o_reg_rdata;
  logic       i_bit_wr;
  logic [5:0] i_bit_addr;
  logic [1:0] i_bit_pos;
  logic       i_bit_val;
  logic       o_ovf_irq;
  logic       o_wdog_reset;
  logic       o_waveform_output_pin;
  int         errors;
  int         n_tests;
  int         n;
  logic       w;
  logic       p0;
  logic       p1;
  logic [3:0] d;
  logic [3:0] e;
  int         div_tab [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};

  trc_timer i_dut (
    .i_sys_clk             (i_sys_clk),
    .i_nrst                (i_nrst),
    .i_cyc_tick            (i_cyc_tick),
    .i_stop                (i_stop),
    .i_reg_wr              (i_reg_wr),
    .i_reg_rd              (i_reg_rd),
    .i_reg_addr            (i_reg_addr),
    .i_reg_wdata           (i_reg_wdata),
    .o_reg_rdata           (o_reg_rdata),
    .i_bit_wr              (i_bit_wr),
    .i_bit_addr            (i_bit_addr),
    .i_bit_pos             (i_bit_pos),
    .i_bit_val             (i_bit_val),
    .o_ovf_irq             (o_ovf_irq),
    .o_wdog_reset          (o_wdog_reset),
    .o_waveform_output_pin (o_waveform_output_pin)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] seen,
                     input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // every access task starts and ends just after a falling edge
  task automatic wr(input logic [5:0] a, input logic [3:0] v);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [3:0] v);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    v = o_reg_rdata;
    @(negedge i_sys_clk);
  endtask

  // high then low nibble in back-to-back cycles, strobe held between
  task automatic rd2(output logic [3:0] hi, output logic [3:0] lo);
    i_reg_addr = trc_pkg::ADDR_CNT_HIGH;
    i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    hi = o_reg_rdata;
    i_reg_addr = trc_pkg::ADDR_CNT_LOW;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    lo = o_reg_rdata;
    @(negedge i_sys_clk);
  endtask

  task automatic bw(input logic [1:0] pos, input logic v);
    i_bit_addr = trc_pkg::ADDR_FLAG_AREA;
    i_bit_pos = pos;
    i_bit_val = v;
    i_bit_wr = 1'b1;
    @(negedge i_sys_clk);
    i_bit_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask

  // counts falling edges up to and including the one that sees the pulse
  task automatic wait_irq(output int cyc);
    cyc = 0;
    p0 = o_waveform_output_pin;
    do
    begin
      @(negedge i_sys_clk);
      cyc++;
    end while (o_ovf_irq !== 1'b1 && cyc < 5000);
    w = o_wdog_reset;
    p1 = o_waveform_output_pin;
    if (cyc >= 5000)
    begin
      errors++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_sys_clk = 1'b0;
    i_nrst = 1'b0;
    i_cyc_tick = 1'b0;
    i_stop = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 6'h00;
    i_reg_wdata = 4'h0;
    i_bit_wr = 1'b0;
    i_bit_addr = 6'h00;
    i_bit_pos = 2'h0;
    i_bit_val = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (16) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    @(negedge i_sys_clk);
    chk("pin", o_waveform_output_pin, 12'h000);
    rd(trc_pkg::ADDR_MODE, d);
    chk("mode read", d, 12'h000);
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("count high", d, 12'h000);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("count low", d, 12'h000);
    rd(trc_pkg::ADDR_FLAG_AREA, d);
    chk("flag", d, 12'h000);
    rd(6'h3F, d);
    chk("unmapped", d, 12'h000);
    // ticks idle, so the counter holds what the pair loaded
    wr(trc_pkg::ADDR_CNT_LOW, 4'h5);
    wr(trc_pkg::ADDR_CNT_HIGH, 4'hA);
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("count high", d, 12'h00A);
    wr(trc_pkg::ADDR_CNT_LOW, 4'hC);
    wr(trc_pkg::ADDR_CNT_HIGH, 4'h3);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("latched low", d, 12'h005);
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("count high", d, 12'h003);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("count low", d, 12'h00C);
    wr(trc_pkg::ADDR_MODE, 4'hF);
    rd(trc_pkg::ADDR_MODE, d);
    chk("mode read", d, 12'h000);
    // nibble write and wrong bit position must leave the flag clear
    wr(trc_pkg::ADDR_FLAG_AREA, 4'hF);
    bw(2'h0, 1'b1);
    rd(trc_pkg::ADDR_FLAG_AREA, d);
    chk("flag", d, 12'h000);
    // free-running overflow from FE, watchdog unarmed
    wr(trc_pkg::ADDR_PORT_MODE, 4'h1);
    wr(trc_pkg::ADDR_MODE, 4'h7);
    wr(trc_pkg::ADDR_CNT_LOW, 4'hE);
    wr(trc_pkg::ADDR_CNT_HIGH, 4'hF);
    i_cyc_tick = 1'b1;
    wait_irq(n);
    i_cyc_tick = 1'b0;
    chk("wdog idle", w, 12'h000);
    chk("pin toggle", p1 ^ p0, 12'h001);
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("wrap high", d, 12'h000);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("wrap low", d, 12'h000);
    // arm the watchdog; a cleared write has no effect
    bw(2'h1, 1'b1);
    bw(2'h1, 1'b0);
    rd(trc_pkg::ADDR_FLAG_AREA, d);
    chk("flag", d, 12'h002);
    // reload overflow from FE back to FE
    wr(trc_pkg::ADDR_MODE, 4'hF);
    wr(trc_pkg::ADDR_CNT_LOW, 4'hE);
    wr(trc_pkg::ADDR_CNT_HIGH, 4'hF);
    i_cyc_tick = 1'b1;
    wait_irq(n);
    i_cyc_tick = 1'b0;
    chk("wdog fire", w, 12'h001);
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("reload high", d, 12'h00F);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("reload low", d, 12'h00E);
    rd2(e, d);
    chk("pair high", e, 12'h00F);
    chk("pair low", d, 12'h00E);
    // reload FF overflows on every selected tick: period equals divisor
    for (int s = 0; s < 8; s++)
    begin
      wr(trc_pkg::ADDR_MODE, {1'b1, s[2:0]});
      wr(trc_pkg::ADDR_CNT_LOW, 4'hF);
      wr(trc_pkg::ADDR_CNT_HIGH, 4'hF);
      i_cyc_tick = 1'b1;
      wait_irq(n);
      wait_irq(n);
      i_cyc_tick = 1'b0;
      chk("period", n[11:0], div_tab[s][11:0]);
      chk("pin toggle", p1 ^ p0, 12'h001);
    end
    // stop mode falls back to free-running, so FF wraps to 00
    wr(trc_pkg::ADDR_MODE, 4'hF);
    i_stop = 1'b1;
    @(negedge i_sys_clk);
    i_stop = 1'b0;
    wr(trc_pkg::ADDR_CNT_HIGH, 4'hF);
    i_cyc_tick = 1'b1;
    wait_irq(n);
    i_cyc_tick = 1'b0;
    rd(trc_pkg::ADDR_CNT_HIGH, d);
    chk("stop high", d, 12'h000);
    rd(trc_pkg::ADDR_CNT_LOW, d);
    chk("stop low", d, 12'h000);
    // an odd number of overflows so far leaves the waveform high
    chk("pin on", o_waveform_output_pin, 12'h001);
    wr(trc_pkg::ADDR_PORT_MODE, 4'h0);
    chk("pin off", o_waveform_output_pin, 12'h000);
    conclude();
  end
endmodule
